// [hw/stbpd_defines.svh]
// stbpd_defines.svh: offsets, field positions, reset values for standby power-down control
// assumes inclusion by bare name from design files
`ifndef STBPD_DEFINES_SVH
`define STBPD_DEFINES_SVH

// ==========================================================
// register map
`define STBPD_ADDR_W          4
`define STBPD_OFS_CONTROL     4'h0
`define STBPD_OFS_STATUS      4'h4

// ==========================================================
// control fields
`define STBPD_BIT_STANDBY_SELECT_SEL    7
`define STBPD_BIT_XTAL_KEEP   4
`define STBPD_BIT_TMR_STOP    2
`define STBPD_CTRL_WMASK      8'h94
`define STBPD_CTRL_RESET      8'h00

// ==========================================================
// status fields
`define STBPD_BIT_ST_SLEEP    0
`define STBPD_BIT_ST_STANDBY  1
`define STBPD_BIT_ST_XTAL_ON  2
`define STBPD_BIT_ST_TMR_ON   3

`endif

// [hw/stbpd_pkg.sv]
// stbpd_pkg.sv: types for standby power-down control
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package stbpd_pkg;

    typedef enum logic [3:0] {
        STBPD_RUN     = 4'h1,
        STBPD_SLEEP   = 4'h2,
        STBPD_STANDBY = 4'h4,
        STBPD_RESET   = 4'h8
    } stbpd_state_e;

    typedef struct packed {
        logic standby_select;
        logic crystal_keep_running;
        logic timer_clock_stop;
    } stbpd_ctrl_s;

    typedef struct packed {
        logic cpu_halt;
        logic periph_halt;
        logic clkgen_halt;
        logic crystal_run;
        logic timer_clk_en;
    } stbpd_pwr_s;

endpackage

`default_nettype wire

// [hw/stbpd_wake.sv]
// stbpd_wake.sv: classifies wake events for the power-down sequencer
// assumes event inputs synchronous to core_clk_i
`default_nettype none

module stbpd_wake
    import stbpd_pkg::*;
(
    // mode
    input  wire logic      in_sleep_i,
    input  wire logic      in_standby_i,
    // events
    input  wire logic      irq_any_i,
    input  wire logic      nmi_i,
    input  wire logic      ext_irq_i,
    // result
    output logic           wake_o
);

    // sleep ends on any interrupt; standby only on nmi or external request
    always_comb begin
        wake_o = (in_sleep_i & irq_any_i) | (in_standby_i & (nmi_i | ext_irq_i));
    end

endmodule

`default_nettype wire

// [hw/stbpd_clkgate.sv]
// stbpd_clkgate.sv: glitch-free clock enable gate for the timer unit
// assumes clk_i is the core clock; enable is sampled on the falling edge
`default_nettype none

module stbpd_clkgate (
    // clock
    input  wire logic      clk_i,
    // control
    input  wire logic      en_i,
    // gated clock
    output logic           gclk_o
);

    logic en_lat_ff;

    // capture enable on the falling clock edge, so the gated clock never gets a cut pulse
    always_ff @(negedge clk_i) begin
        en_lat_ff <= en_i;
    end

    assign gclk_o = clk_i & en_lat_ff;

endmodule

`default_nettype wire

// [hw/stbpd_top.sv]
// stbpd_top.sv: standby control register and power-down mode sequencer
// assumes a single core clock, synchronous active-high reset and a plain register port
//
// Overview of operation
// - low on poweron_reset_n starts power-on reset processing
// - control register cleared by power-on reset, kept across manual reset
// - bit 7 clear: sleep instruction enters sleep; set: software standby
// - bit 4 clear stops crystal in standby; set keeps it oscillating
// - bit 2 set halts timer unit clock; clear lets timer run outside standby
// - reserved bits 6,5,3,1,0 read zero; software writes zero there
// - sleep: cpu halts, clocks and peripherals run; interrupt or reset ends it
// - standby: all halt; nmi, external request or power-on reset ends it
`include "stbpd_defines.svh"
`default_nettype none

module stbpd_top
    import stbpd_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       poweron_reset_n_i,
    input  wire logic                       manual_reset_i,
    // register port
    input  wire logic [`STBPD_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [7:0]                 reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [7:0]                 reg_rdata_o,
    // cpu side
    input  wire logic                       sleep_exec_i,
    input  wire logic                       irq_any_i,
    input  wire logic                       nmi_i,
    input  wire logic                       ext_irq_i,
    // power controls
    output logic                            cpu_halt_o,
    output logic                            periph_halt_o,
    output logic                            clkgen_halt_o,
    output logic                            crystal_run_o,
    output logic                            poweron_reset_o,
    output logic                            timer_clk_o
);

    // ==========================================================
    // state
    stbpd_ctrl_s   ctrl_ff,   nxt_ctrl;
    stbpd_ctrl_s   ctrl_eff;
    stbpd_state_e  state_ff,  nxt_state;
    stbpd_pwr_s    pwr_ff,    nxt_pwr;
    logic [7:0]    rdata_ff,  nxt_rdata;
    logic          por_ff,    nxt_por;
    logic          wake;
    logic          por_req;

    // both the port reset and the pin count as power-on reset
    assign por_req = reset_i | ~poweron_reset_n_i;

    // ==========================================================
    // wake decode
    stbpd_wake u_wake (
        .in_sleep_i   (state_ff == STBPD_SLEEP),
        .in_standby_i (state_ff == STBPD_STANDBY),
        .irq_any_i    (irq_any_i),
        .nmi_i        (nmi_i),
        .ext_irq_i    (ext_irq_i),
        .wake_o       (wake)
    );

    // ==========================================================
    // control register
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (reg_wr_i && reg_addr_i == `STBPD_OFS_CONTROL) begin
            nxt_ctrl.standby_select       = reg_wdata_i[`STBPD_BIT_STANDBY_SELECT_SEL];
            nxt_ctrl.crystal_keep_running = reg_wdata_i[`STBPD_BIT_XTAL_KEEP];
            nxt_ctrl.timer_clock_stop     = reg_wdata_i[`STBPD_BIT_TMR_STOP];
        end
    end

    // manual reset deliberately not used here
    always_ff @(posedge core_clk_i) begin
        if (por_req) begin
            ctrl_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ==========================================================
    // control value seen by the sequencer
    always_comb begin
        ctrl_eff = nxt_ctrl;
        if (por_req) begin
            ctrl_eff = '0;
        end
    end

    // ==========================================================
    // read data, one cycle after strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `STBPD_OFS_CONTROL: begin
                    nxt_rdata[`STBPD_BIT_STANDBY_SELECT_SEL]  = ctrl_ff.standby_select;
                    nxt_rdata[`STBPD_BIT_XTAL_KEEP] = ctrl_ff.crystal_keep_running;
                    nxt_rdata[`STBPD_BIT_TMR_STOP]  = ctrl_ff.timer_clock_stop;
                end
                `STBPD_OFS_STATUS: begin
                    nxt_rdata[`STBPD_BIT_ST_SLEEP]   = (state_ff == STBPD_SLEEP);
                    nxt_rdata[`STBPD_BIT_ST_STANDBY] = (state_ff == STBPD_STANDBY);
                    nxt_rdata[`STBPD_BIT_ST_XTAL_ON] = pwr_ff.crystal_run;
                    nxt_rdata[`STBPD_BIT_ST_TMR_ON]  = pwr_ff.timer_clk_en;
                end
                default: begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // mode sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_por   = 1'b0;
        case (state_ff)
            STBPD_RESET: begin
                nxt_state = STBPD_RUN;
            end
            STBPD_RUN: begin
                if (manual_reset_i) begin
                    nxt_state = STBPD_RUN;
                end else if (sleep_exec_i) begin
                    nxt_state = nxt_ctrl.standby_select ? STBPD_STANDBY : STBPD_SLEEP;
                end
            end
            STBPD_SLEEP: begin
                if (wake || manual_reset_i) begin
                    nxt_state = STBPD_RUN;
                end
            end
            STBPD_STANDBY: begin
                if (wake) begin
                    nxt_state = STBPD_RUN;
                end
            end
            default: begin
                nxt_state = STBPD_RESET;
            end
        endcase
        if (por_req) begin
            nxt_state = STBPD_RESET;
            nxt_por   = 1'b1;
        end
    end

    always_comb begin
        nxt_pwr.cpu_halt     = (nxt_state == STBPD_SLEEP) | (nxt_state == STBPD_STANDBY);
        nxt_pwr.periph_halt  = (nxt_state == STBPD_STANDBY);
        nxt_pwr.clkgen_halt  = (nxt_state == STBPD_STANDBY);
        nxt_pwr.crystal_run  = (nxt_state != STBPD_STANDBY) | ctrl_eff.crystal_keep_running;
        nxt_pwr.timer_clk_en = ~ctrl_eff.timer_clock_stop & (nxt_state != STBPD_STANDBY);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_ff <= STBPD_RESET;
            pwr_ff   <= 5'h02;
            por_ff   <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            pwr_ff   <= nxt_pwr;
            por_ff   <= nxt_por;
        end
    end

    // ==========================================================
    // timer clock gate
    stbpd_clkgate u_tmr_gate (
        .clk_i  (core_clk_i),
        .en_i   (pwr_ff.timer_clk_en),
        .gclk_o (timer_clk_o)
    );

    // ==========================================================
    // outputs
    assign reg_rdata_o     = rdata_ff;
    assign cpu_halt_o      = pwr_ff.cpu_halt;
    assign periph_halt_o   = pwr_ff.periph_halt;
    assign clkgen_halt_o   = pwr_ff.clkgen_halt;
    assign crystal_run_o   = pwr_ff.crystal_run;
    assign poweron_reset_o = por_ff;

    // ==========================================================
    // checks
    a_por_clears_ctrl: assert property (@(posedge core_clk_i)
        !poweron_reset_n_i |=> ctrl_ff == '0)
        else $error("control not cleared by power-on reset");
    a_manual_keeps: assert property (@(posedge core_clk_i) disable iff (por_req)
        !por_req && manual_reset_i && !reg_wr_i |=> $stable(ctrl_ff))
        else $error("control changed on manual reset");
    a_por_state: assert property (@(posedge core_clk_i)
        !poweron_reset_n_i |=> state_ff == STBPD_RESET && poweron_reset_o)
        else $error("power-on reset not started");
    a_sleep_sel: assert property (@(posedge core_clk_i) disable iff (por_req)
        !por_req && state_ff == STBPD_RUN && sleep_exec_i && !manual_reset_i && !reg_wr_i
        |=> (state_ff == STBPD_STANDBY) == $past(ctrl_ff.standby_select))
        else $error("wrong power-down mode chosen");
    a_xtal_standby: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_ff == STBPD_STANDBY |-> crystal_run_o == ctrl_ff.crystal_keep_running)
        else $error("crystal state wrong in standby");
    a_tmr_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ctrl_ff.timer_clock_stop |-> !pwr_ff.timer_clk_en)
        else $error("timer clock not stopped");
    a_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $past(reg_rd_i) && $past(reg_addr_i) == `STBPD_OFS_CONTROL
        |-> (reg_rdata_o & ~`STBPD_CTRL_WMASK) == 8'h00)
        else $error("reserved bits not zero");
    a_sleep_periph: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_ff == STBPD_SLEEP |-> cpu_halt_o && !periph_halt_o && !clkgen_halt_o)
        else $error("sleep halts wrong units");
    a_standby_hold: assert property (@(posedge core_clk_i) disable iff (por_req)
        !por_req && state_ff == STBPD_STANDBY && !nmi_i && !ext_irq_i
        |=> state_ff == STBPD_STANDBY)
        else $error("standby left without wake source");
    a_standby_wake: assert property (@(posedge core_clk_i) disable iff (por_req)
        !por_req && state_ff == STBPD_STANDBY && nmi_i
        |=> state_ff == STBPD_RUN && !cpu_halt_o)
        else $error("standby not left on nmi");

    // ==========================================================
    // reset and register checks
    a_reset_state: assert property (@(posedge core_clk_i)
        reset_i |=> state_ff == STBPD_RESET && poweron_reset_o
        && crystal_run_o && !cpu_halt_o && !pwr_ff.timer_clk_en)
        else $error("outputs wrong after reset");
    a_por_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req |=> !poweron_reset_o)
        else $error("power-on flag without reset");
    a_reset_clears: assert property (@(posedge core_clk_i)
        reset_i |=> ctrl_ff == '0)
        else $error("control not cleared by reset");
    a_ctrl_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req && !(reg_wr_i && reg_addr_i == `STBPD_OFS_CONTROL) |=> $stable(ctrl_ff))
        else $error("control changed without a write");
    a_write_lands: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req && reg_wr_i && reg_addr_i == `STBPD_OFS_CONTROL
        |=> ctrl_ff.standby_select == $past(reg_wdata_i[`STBPD_BIT_STANDBY_SELECT_SEL])
        && ctrl_ff.crystal_keep_running == $past(reg_wdata_i[`STBPD_BIT_XTAL_KEEP])
        && ctrl_ff.timer_clock_stop == $past(reg_wdata_i[`STBPD_BIT_TMR_STOP]))
        else $error("control write lost");

    // ==========================================================
    // mode checks
    a_sleep_enter: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req && state_ff == STBPD_RUN && sleep_exec_i && !manual_reset_i && !reg_wr_i
        && !ctrl_ff.standby_select |=> state_ff == STBPD_SLEEP && !periph_halt_o)
        else $error("sleep not entered");
    a_xtal_run: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_ff != STBPD_STANDBY |-> crystal_run_o)
        else $error("crystal stopped outside standby");
    a_tmr_run: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_ff == STBPD_RUN || state_ff == STBPD_SLEEP) && !ctrl_ff.timer_clock_stop
        |-> pwr_ff.timer_clk_en)
        else $error("timer clock stopped while enabled");
    a_sleep_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req && state_ff == STBPD_SLEEP && !irq_any_i && !manual_reset_i
        |=> state_ff == STBPD_SLEEP)
        else $error("sleep left without wake source");
    a_sleep_wake: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req && state_ff == STBPD_SLEEP && (irq_any_i || manual_reset_i)
        |=> state_ff == STBPD_RUN && !cpu_halt_o)
        else $error("sleep not left on interrupt");
    a_standby_halt: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_ff == STBPD_STANDBY |-> cpu_halt_o && periph_halt_o && clkgen_halt_o
        && !pwr_ff.timer_clk_en)
        else $error("standby does not halt all units");
    a_standby_ext: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !por_req && state_ff == STBPD_STANDBY && ext_irq_i |=> state_ff == STBPD_RUN)
        else $error("standby not left on external request");

    // ==========================================================
    // timer gate check
    a_gate_cycle: assert property (@(negedge core_clk_i) disable iff (reset_i)
        timer_clk_o == $past(pwr_ff.timer_clk_en))
        else $error("timer clock pulse cut or late");

    // ==========================================================
    // scenario covers
    c_sleep:   cover property (@(posedge core_clk_i)
        state_ff == STBPD_SLEEP ##[1:20] state_ff == STBPD_RUN);
    c_standby: cover property (@(posedge core_clk_i)
        state_ff == STBPD_STANDBY ##[1:20] state_ff == STBPD_RUN);
    c_tmrstop: cover property (@(posedge core_clk_i) $fell(pwr_ff.timer_clk_en));
    c_xtal_keep: cover property (@(posedge core_clk_i)
        state_ff == STBPD_STANDBY && crystal_run_o);
    c_same_write: cover property (@(posedge core_clk_i)
        state_ff == STBPD_RUN && sleep_exec_i && reg_wr_i ##1 state_ff == STBPD_STANDBY);

endmodule

`default_nettype wire

// [testbench/stbpd_top_tb.sv]
// stbpd_top_tb.sv: self-checking bench for the standby power-down control block
// assumes stbpd_pkg and stbpd_top are compiled first; the bench drives all ports itself
`include "stbpd_defines.svh"
`default_nettype none

module stbpd_top_tb
    import stbpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // signals
    logic                     core_clk_i;
    logic                     reset_i;
    logic                     poweron_reset_n_i;
    logic [`STBPD_ADDR_W-1:0] reg_addr_i;
    logic [7:0]               reg_wdata_i;
    logic                     reg_wr_i;
    logic                     reg_rd_i;
    logic [7:0]               reg_rdata_o;
    logic [4:0]               ev;
    logic                     cpu_halt_o;
    logic                     periph_halt_o;
    logic                     clkgen_halt_o;
    logic                     crystal_run_o;
    logic                     poweron_reset_o;
    logic                     timer_clk_o;
    int                       n_mismatch;
    int                       n_tests;
    int                       tclk_cnt;

    // ev: 0 sleep, 1 irq, 2 nmi, 3 external request, 4 manual reset
    localparam logic [4:0] EV_SLP = 5'h01;
    localparam logic [4:0] EV_IRQ = 5'h02;
    localparam logic [4:0] EV_NMI = 5'h04;
    localparam logic [4:0] EV_EXT = 5'h08;
    localparam logic [4:0] EV_MAN = 5'h10;

    stbpd_top u_stbpd_top (
        .core_clk_i        (core_clk_i),
        .reset_i           (reset_i),
        .poweron_reset_n_i (poweron_reset_n_i),
        .manual_reset_i    (ev[4]),
        .reg_addr_i        (reg_addr_i),
        .reg_wdata_i       (reg_wdata_i),
        .reg_wr_i          (reg_wr_i),
        .reg_rd_i          (reg_rd_i),
        .reg_rdata_o       (reg_rdata_o),
        .sleep_exec_i      (ev[0]),
        .irq_any_i         (ev[1]),
        .nmi_i             (ev[2]),
        .ext_irq_i         (ev[3]),
        .cpu_halt_o        (cpu_halt_o),
        .periph_halt_o     (periph_halt_o),
        .clkgen_halt_o     (clkgen_halt_o),
        .crystal_run_o     (crystal_run_o),
        .poweron_reset_o   (poweron_reset_o),
        .timer_clk_o       (timer_clk_o)
    );

    // ==========================================================
    // clock, timer edge counter, watchdog
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    always @(posedge timer_clk_o) tclk_cnt++;

    initial begin
        repeat (5000) @(posedge core_clk_i);
        n_mismatch++;
        end_of_test();
    end

    // ==========================================================
    // tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one cycle of stimulus, released at the next edge
    task automatic drive(input logic [3:0] a, input logic [7:0] d, input logic wr,
                         input logic rd, input logic [4:0] e);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= wr;
        reg_rd_i    <= rd;
        ev          <= e;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b0;
        ev          <= 5'h00;
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        drive(a, d, 1'b1, 1'b0, 5'h00);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        drive(a, 8'h00, 1'b0, 1'b1, 5'h00);
        check("read data", reg_rdata_o, exp);
    endtask

    task automatic pwr_chk(input logic [3:0] exp);
        check("power controls", {4'h0, cpu_halt_o, periph_halt_o, clkgen_halt_o,
              crystal_run_o}, {4'h0, exp});
    endtask

    // timer clock edges over eight core cycles
    task automatic tclk_chk(input logic [7:0] exp);
        tclk_cnt = 0;
        repeat (8) @(posedge core_clk_i);
        #1;
        check("timer clock edges", 8'(tclk_cnt), exp);
    endtask

    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        tclk_cnt = 0;
        reset_i = 1'b1;
        poweron_reset_n_i = 1'b1;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        ev = 5'h00;
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1;
        check("poweron flag in reset", {7'h0, poweron_reset_o}, 8'h01);
        rd_chk(`STBPD_OFS_CONTROL, 8'h00);
        check("poweron flag after reset", {7'h0, poweron_reset_o}, 8'h00);
        rd_chk(`STBPD_OFS_STATUS, 8'h0C);
        wr(`STBPD_OFS_CONTROL, 8'h94);
        rd_chk(`STBPD_OFS_CONTROL, 8'h94);
        wr(`STBPD_OFS_STATUS, 8'hFF);
        rd_chk(`STBPD_OFS_STATUS, 8'h04);
        rd_chk(4'h2, 8'h00);
        tclk_chk(8'h00);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_MAN);
        rd_chk(`STBPD_OFS_CONTROL, 8'h94);
        @(posedge core_clk_i);
        poweron_reset_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        check("poweron flag from pin", {7'h0, poweron_reset_o}, 8'h01);
        @(posedge core_clk_i);
        poweron_reset_n_i <= 1'b1;
        rd_chk(`STBPD_OFS_CONTROL, 8'h00);
        tclk_chk(8'h08);
        // sleep mode, ended by interrupt and by manual reset
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_SLP);
        pwr_chk(4'h9);
        tclk_chk(8'h08);
        rd_chk(`STBPD_OFS_STATUS, 8'h0D);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_SLP);
        pwr_chk(4'h9);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_IRQ);
        pwr_chk(4'h1);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_SLP);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_MAN);
        pwr_chk(4'h1);
        // standby chosen by a write in the same cycle as the sleep instruction
        drive(`STBPD_OFS_CONTROL, 8'h80, 1'b1, 1'b0, EV_SLP);
        pwr_chk(4'hE);
        tclk_chk(8'h00);
        rd_chk(`STBPD_OFS_STATUS, 8'h02);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_IRQ);
        pwr_chk(4'hE);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_MAN);
        pwr_chk(4'hE);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_EXT);
        pwr_chk(4'h1);
        // standby with crystal kept, ended by nmi
        wr(`STBPD_OFS_CONTROL, 8'h90);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_SLP);
        pwr_chk(4'hF);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_NMI);
        pwr_chk(4'h1);
        // standby ended by the power-on reset pin
        wr(`STBPD_OFS_CONTROL, 8'h80);
        drive(4'h0, 8'h00, 1'b0, 1'b0, EV_SLP);
        pwr_chk(4'hE);
        @(posedge core_clk_i);
        poweron_reset_n_i <= 1'b0;
        @(posedge core_clk_i);
        poweron_reset_n_i <= 1'b1;
        #1;
        pwr_chk(4'h1);
        rd_chk(`STBPD_OFS_CONTROL, 8'h00);
        end_of_test();
    end

endmodule

`default_nettype wire
